//--- strap_pkg.sv
// Constants for the power-up strap decoder.
// Assumes one 20 MHz clock and straps held stable through reset.
package strap_pkg;
   // Platform multiplier encoded as N for N:1, zero when reserved
   localparam logic [4:0] PLAT_MULT_RSVD = 5'h00;
   localparam logic [4:0] PLAT_MULT_16   = 5'h10;
   localparam logic [3:0] PLAT_CODE_16   = 4'h0;
   localparam logic [3:0] PLAT_CODE_2    = 4'h2;
   localparam logic [3:0] PLAT_CODE_6    = 4'h6;
   localparam logic [3:0] PLAT_CODE_8    = 4'h8;
   localparam logic [3:0] PLAT_CODE_10   = 4'ha;
   localparam logic [3:0] PLAT_CODE_12   = 4'hc;
   // Core ratio in half steps: core = platform * value / 2
   localparam logic [2:0] CORE_HALF_2_0  = 3'h4;
   localparam logic [2:0] CORE_HALF_2_5  = 3'h5;
   localparam logic [2:0] CORE_HALF_3_0  = 3'h6;
   localparam logic [2:0] CORE_HALF_3_5  = 3'h7;
   // Memory bus divider from platform clock
   localparam logic [1:0] MEM_DIV        = 2'h2;
   localparam int         PLAT_MIN_MHZ   = 200;
endpackage

//--- strap_decode.sv
// Strap sampler and ratio decoder.
// Straps come from pins, so they are synchronised before use.
`timescale 1ns/1ps
module strap_decode (
   input  wire logic       CLK,
   input  wire logic       RESET_N,
   input  wire logic       CLK_EN,
   input  wire logic [3:0] PLATFORM_RATIO_STRAP,
   input  wire logic       CORE_RATIO_STRAP_HI,
   input  wire logic       CORE_RATIO_STRAP_LO,
   input  wire logic       BUS_WIDTH_STRAP,
   output logic      [4:0] PLAT_MULT,
   output logic            PLAT_RSVD,
   output logic      [2:0] CORE_HALF_RATIO,
   output logic      [1:0] MEM_DIV_OUT,
   output logic            WIDE_64,
   output logic            CFG_VALID
);
   logic [1:0] rst_sync_r;
   logic       rst_n;
   logic [6:0] strap_s1_r;
   logic [6:0] strap_s2_r;
   logic       sampled_r;
   logic [3:0] pcode;
   logic [4:0] mult_nxt;
   logic [2:0] core_nxt;
   logic       in_range;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) rst_sync_r <= 2'h0;
      else if (CLK_EN) rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // Two flops per strap pin; cleared while the pin reset is low
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         strap_s1_r <= 7'h00;
         strap_s2_r <= 7'h00;
      end else if (CLK_EN) begin
         strap_s1_r <= {BUS_WIDTH_STRAP, CORE_RATIO_STRAP_HI,
                        CORE_RATIO_STRAP_LO, PLATFORM_RATIO_STRAP};
         strap_s2_r <= strap_s1_r;
      end
   end

   assign pcode = strap_s2_r[3:0];
   // Straps floating give garbage; no default exists
   assign in_range = (pcode >= strap_pkg::PLAT_CODE_2 &&
                      pcode <= strap_pkg::PLAT_CODE_6) ||
                     (pcode >= strap_pkg::PLAT_CODE_8 &&
                      pcode <= strap_pkg::PLAT_CODE_10) ||
                     (pcode == strap_pkg::PLAT_CODE_12);
   assign mult_nxt = (pcode == strap_pkg::PLAT_CODE_16) ?
                     strap_pkg::PLAT_MULT_16 :
                     in_range ? {1'b0, pcode} :
                     strap_pkg::PLAT_MULT_RSVD;
   assign core_nxt = {1'b1, strap_s2_r[5:4]};

   // Capture once, on the first enabled edge after the internal reset rst_n goes high
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sampled_r       <= 1'b0;
         PLAT_MULT       <= strap_pkg::PLAT_MULT_RSVD;
         PLAT_RSVD       <= 1'b0;
         CORE_HALF_RATIO <= strap_pkg::CORE_HALF_2_0;
         MEM_DIV_OUT     <= strap_pkg::MEM_DIV;
         WIDE_64         <= 1'b0;
         CFG_VALID       <= 1'b0;
      end else if (CLK_EN && !rst_n) begin
         sampled_r <= 1'b0;
         CFG_VALID <= 1'b0;
      end else if (CLK_EN && !sampled_r) begin
         sampled_r       <= 1'b1;
         PLAT_MULT       <= mult_nxt;
         PLAT_RSVD       <= (mult_nxt == strap_pkg::PLAT_MULT_RSVD);
         CORE_HALF_RATIO <= core_nxt;
         MEM_DIV_OUT     <= strap_pkg::MEM_DIV;
         WIDE_64         <= ~strap_s2_r[6];
         CFG_VALID       <= 1'b1;
      end
   end

   // Checks share the sampler clock; nothing is judged in internal reset
   default clocking chk_clk @(posedge CLK);
   endclocking
   default disable iff (!rst_n);

   // Named views of the synchronised straps, read only by the checks
   logic [1:0] core_code;
   logic       width_strap;
   logic       band_low;
   logic       band_high;
   logic       code_twelve;
   logic       code_zero;
   logic       code_listed;
   assign core_code   = strap_s2_r[5:4];
   assign width_strap = strap_s2_r[6];
   assign band_low    = (pcode >= strap_pkg::PLAT_CODE_2) &&
                        (pcode <= strap_pkg::PLAT_CODE_6);
   assign band_high   = (pcode >= strap_pkg::PLAT_CODE_8) &&
                        (pcode <= strap_pkg::PLAT_CODE_10);
   assign code_twelve = (pcode == strap_pkg::PLAT_CODE_12);
   assign code_zero   = (pcode == strap_pkg::PLAT_CODE_16);
   assign code_listed = code_zero || band_low || band_high || code_twelve;

   // Once locked, nothing moves until the next reset
   chk_hold_after_lock: assert property (
      (CFG_VALID && $past(CFG_VALID) && $past(CLK_EN)) |->
      ($stable(PLAT_MULT) && $stable(PLAT_RSVD) &&
       $stable(CORE_HALF_RATIO) && $stable(WIDE_64) &&
       $stable(MEM_DIV_OUT)))
      else $error("Config changed after lock");

   // Enable low freezes CFG_VALID, PLAT_MULT and WIDE_64, locked or not
   chk_freeze_off: assert property (
      !$past(CLK_EN) |->
      ($stable(CFG_VALID) && $stable(PLAT_MULT) && $stable(WIDE_64)))
      else $error("Output moved with enable low");

   // Only a reset may take the lock away again
   chk_capture_once: assert property (
      $past(CFG_VALID) |-> CFG_VALID)
      else $error("Lock dropped without reset");

   // Bounded wait for the lock after the internal reset lifts
   chk_valid_soon: assert property (
      $rose(rst_n) |-> ##[0:8] (CFG_VALID || !CLK_EN))
      else $error("Config not valid after reset");

   // With enable high, capture lands on the very next edge
   chk_valid_edge: assert property (
      ($rose(rst_n) && CLK_EN) |-> ##1 CFG_VALID)
      else $error("Config late after reset");

   // Core ratio always lies in the upper half of the code space
   chk_core_decode: assert property (
      CFG_VALID |-> (CORE_HALF_RATIO >= strap_pkg::CORE_HALF_2_0))
      else $error("Core ratio decode wrong");

   // One check per core code, against the named ratios
   chk_core_two: assert property (
      ($rose(CFG_VALID) && $past(core_code) == 2'h0) |->
      (CORE_HALF_RATIO == strap_pkg::CORE_HALF_2_0))
      else $error("Core code 00 must give 2 to 1");

   chk_core_five_half: assert property (
      ($rose(CFG_VALID) && $past(core_code) == 2'h1) |->
      (CORE_HALF_RATIO == strap_pkg::CORE_HALF_2_5))
      else $error("Core code 01 must give 5 to 2");

   chk_core_three: assert property (
      ($rose(CFG_VALID) && $past(core_code) == 2'h2) |->
      (CORE_HALF_RATIO == strap_pkg::CORE_HALF_3_0))
      else $error("Core code 10 must give 3 to 1");

   chk_core_seven_half: assert property (
      ($rose(CFG_VALID) && $past(core_code) == 2'h3) |->
      (CORE_HALF_RATIO == strap_pkg::CORE_HALF_3_5))
      else $error("Core code 11 must give 7 to 2");

   // Width strap low asks for the wide host bus
   chk_width_low: assert property (
      ($rose(CFG_VALID) && !$past(width_strap)) |-> WIDE_64)
      else $error("Width strap low must select wide");

   chk_width_high: assert property (
      ($rose(CFG_VALID) && $past(width_strap)) |-> !WIDE_64)
      else $error("Width strap high must select narrow");

   // Code zero is the largest multiplier, not a reserved one
   chk_sixteen_code: assert property (
      ($rose(CFG_VALID) && $past(code_zero)) |->
      (PLAT_MULT == strap_pkg::PLAT_MULT_16 && !PLAT_RSVD))
      else $error("Code zero must give sixteen");

   // Listed bands give the strap value itself as multiplier
   chk_mult_range: assert property (
      ($rose(CFG_VALID) &&
       $past(band_low || band_high || code_twelve)) |->
      (PLAT_MULT == {1'b0, $past(pcode)} && !PLAT_RSVD))
      else $error("Multiplier not strap value");

   // Unlisted codes must never yield a usable multiplier
   chk_rsvd_code: assert property (
      ($rose(CFG_VALID) && !$past(code_listed)) |->
      (PLAT_RSVD && PLAT_MULT == strap_pkg::PLAT_MULT_RSVD))
      else $error("Reserved code not flagged");

   chk_rsvd_flag: assert property (
      CFG_VALID |-> (PLAT_RSVD == (PLAT_MULT == strap_pkg::PLAT_MULT_RSVD)))
      else $error("Reserved flag mismatch");

   // Memory bus runs at half the platform clock, whatever the straps
   chk_mem_half: assert property (
      MEM_DIV_OUT == strap_pkg::MEM_DIV)
      else $error("Memory divider not two");

   // Main scenarios worth seeing at least once
   cov_wide: cover property ($rose(CFG_VALID) && WIDE_64);
   cov_rsvd: cover property ($rose(CFG_VALID) && PLAT_RSVD);
   cov_core7: cover property (
      $rose(CFG_VALID) && CORE_HALF_RATIO == strap_pkg::CORE_HALF_3_5);
   cov_sixteen: cover property (
      $rose(CFG_VALID) && PLAT_MULT == strap_pkg::PLAT_MULT_16);
   cov_frozen: cover property (CFG_VALID && !CLK_EN);
endmodule

//--- strap_board.sv
// Board model: pull resistors holding every strap level.
// Assumes the bench sets every strap level, reserved codes included, before reset ends.
`timescale 1ns/1ps
module strap_board (
   input  wire logic [6:0] levels,
   output logic      [3:0] plat,
   output logic            hi,
   output logic            lo,
   output logic            width
);
   // Hard pulls, never floating, width taken from bit 0 of levels
   assign {plat, hi, lo, width} = levels;
endmodule

//--- tb_top.sv
// Self-checking bench for the strap decoder.
// Assumes one 20 MHz clock and the board model on the straps.
`timescale 1ns/1ps
module tb_top;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       en = 1'b1;
   logic [6:0] lv = 7'h00;
   logic [3:0] plat;
   logic       hi, lo, wd, rsvd, wide, valid;
   logic [4:0] mult;
   logic [2:0] core;
   logic [1:0] mdiv;
   int         err_count = 0;
   int         compares = 0;
   always #25 clk = ~clk;
   strap_board board (.levels(lv), .plat(plat), .hi(hi), .lo(lo),
      .width(wd));
   strap_decode dut (.CLK(clk), .RESET_N(rst_n), .CLK_EN(en),
      .PLATFORM_RATIO_STRAP(plat), .CORE_RATIO_STRAP_HI(hi),
      .CORE_RATIO_STRAP_LO(lo), .BUS_WIDTH_STRAP(wd), .PLAT_MULT(mult),
      .PLAT_RSVD(rsvd), .CORE_HALF_RATIO(core), .MEM_DIV_OUT(mdiv),
      .WIDE_64(wide), .CFG_VALID(valid));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("%0d mismatches in %0d compares", err_count, compares);
      if (err_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic logic [4:0] exp_mult(input logic [3:0] c);
      if (c == 4'h0) return 5'h10;
      if ((c >= 4'h2 && c <= 4'h6) || (c >= 4'h8 && c <= 4'ha) || c == 4'hc)
         return {1'b0, c};
      return 5'h00;
   endfunction
   // Straps held before and well after release, as the sampler needs
   task automatic boot(input logic [6:0] v);
      @(posedge clk);
      lv <= v;
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check(valid, 1'b0);
      @(posedge clk);
      #1 check(valid, 1'b1);
   endtask
   task automatic decode_all;
      for (int i = 0; i < 16; i++) begin
         boot({i[3:0], i[1:0], i[0]});
         check(mult, exp_mult(i[3:0]));
         check(rsvd, exp_mult(i[3:0]) == 5'h00);
         check(core, {1'b1, i[1:0]});
         check(mdiv, 2'h2);
         check(wide, {7'h00, ~i[0]});
      end
   endtask
   task automatic hold_and_freeze;
      boot(7'h64);
      @(posedge clk);
      lv <= 7'h7f;
      repeat (8) @(posedge clk);
      #1 check(mult, 5'h0c);
      check(wide, 1'b1);
      @(posedge clk);
      en <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check(valid, 1'b1);
      check(core, 3'h6);
      @(posedge clk);
      en <= 1'b1;
      @(posedge clk);
      en <= 1'b0;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1 check(valid, 1'b0);
      @(posedge clk);
      en <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check(valid, 1'b1);
      check(rsvd, 1'b1);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      decode_all();
      hold_and_freeze();
      complete_run();
   end
   // Whole run needs under 500 cycles
   initial begin
      #100000;
      err_count++;
      complete_run();
   end
endmodule
